//--- rtl/ppom_consts.vh
// Constants for the port B pin override multiplexer: offsets, fields, encodings
`ifndef PPOM_CONSTS_VH
`define PPOM_CONSTS_VH

// Register byte offsets on APB
`define PPOM_ADDR_OUT        8'h00
`define PPOM_ADDR_DIR        8'h04
`define PPOM_ADDR_PIN        8'h08
`define PPOM_ADDR_CPU_CTRL   8'h0C
`define PPOM_ADDR_EXTINT     8'h10

// Reset values
`define PPOM_RST_BYTE        8'h00
`define PPOM_RST_WORD        32'h0000_0000
`define PPOM_RST_SENSE       2'h0

// Control register field
`define PPOM_CTRL_PUD_BIT    0

// External interrupt register fields
`define PPOM_EXT_EN_BIT      0
`define PPOM_EXT_SENSE_LO    1
`define PPOM_EXT_SENSE_HI    2
`define PPOM_EXT_FLAG_BIT    3
`define PPOM_EXT_LEVEL_BIT   4

// External interrupt sense encodings
`define PPOM_SENSE_LOW       2'h0
`define PPOM_SENSE_CHANGE    2'h1
`define PPOM_SENSE_FALL      2'h2
`define PPOM_SENSE_RISE      2'h3

// Sleep controller mode encodings
`define PPOM_SLP_ACTIVE      3'h0
`define PPOM_SLP_IDLE        3'h1
`define PPOM_SLP_ADC_NR      3'h2
`define PPOM_SLP_POWER_DOWN  3'h3
`define PPOM_SLP_POWER_SAVE  3'h4
`define PPOM_SLP_STANDBY     3'h6

// Port B pin indices of the alternate functions
`define PPOM_PIN_SS          0
`define PPOM_PIN_SCK         1
`define PPOM_PIN_MOSI        2
`define PPOM_PIN_MISO        3
`define PPOM_PIN_T0_CMP_A    4
`define PPOM_PIN_T1_CMP_A    5
`define PPOM_PIN_T1_CMP_B    6
`define PPOM_PIN_T2_CMP_A    7

// Override enables and values tied low where no module drives them
`define PPOM_NO_TOGGLE       8'h00
`define PPOM_ZERO_BYTE       8'h00

`endif

//--- rtl/ppom_pin_sync.v
// Two-stage input synchroniser, one lane per bit
`timescale 1ns/1ns
module ppom_pin_sync #(
    parameter WIDTH = 8                          // Number of lanes
) (
    input  wire             i_clk,               // System clock
    input  wire             i_resetn,            // Async reset, active low
    input  wire [WIDTH-1:0] i_async,             // Asynchronous level
    output wire [WIDTH-1:0] o_sync               // Synchronised level
);

    reg [WIDTH-1:0] stage1_ff;                   // Read only by stage2
    reg [WIDTH-1:0] stage2_ff;                   // Safe copy

    // Two flops; first stage may go metastable, nothing else looks at it
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage1_ff <= {WIDTH{1'b0}};
            stage2_ff <= {WIDTH{1'b0}};
        end else begin
            stage1_ff <= i_async;
            stage2_ff <= stage1_ff;
        end
    end

    assign o_sync = stage2_ff;

endmodule // ppom_pin_sync

//--- rtl/ppom_pin_cell.v
// Combinational override logic of one port pin
`timescale 1ns/1ns
module ppom_pin_cell (
    input  wire i_resetn,                        // Async reset, active low
    input  wire i_pin_direction_bit,             // Direction register bit
    input  wire i_pin_output_latch,              // Output latch bit
    input  wire i_global_pullup_disable,         // Global pull-up disable
    input  wire i_sleep_clamp,                   // Deep sleep clamp request
    input  wire i_pullup_override_en,            // Pull-up override enable
    input  wire i_pullup_override_val,           // Pull-up override value
    input  wire i_dir_override_en,               // Direction override enable
    input  wire i_dir_override_val,              // Direction override value
    input  wire i_value_override_en,             // Port value override enable
    input  wire i_value_override_val,            // Port value override value
    input  wire i_input_en_override_en,          // Input enable override enable
    input  wire i_input_en_override_val,         // Input enable override value
    input  wire i_pad_in,                        // Pad level after Schmitt trigger
    output wire o_pad_out,                       // Level driven onto the pad
    output wire o_pad_oe_n,                      // Driver enable, active low
    output wire o_pullup_en,                     // Pull-up enable
    output wire o_alt_digital_in                 // Clamped input, before sync
);

    wire gp_pullup;                              // Plain port pull-up
    wire pullup_sel;                             // After override
    wire drive_en;                               // Output driver enable
    wire input_en;                               // Digital input enable
    // Pull-up only for direction 0, latch 1, disable 0
    assign gp_pullup  = ~i_pin_direction_bit & i_pin_output_latch & ~i_global_pullup_disable;
    assign pullup_sel = i_pullup_override_en ? i_pullup_override_val : gp_pullup;
    // Pull-up forced off while reset is held, even without clock
    assign o_pullup_en = pullup_sel & i_resetn;

    // Driver enable from override or direction bit; tri-state in reset
    assign drive_en   = (i_dir_override_en ? i_dir_override_val : i_pin_direction_bit) & i_resetn;
    assign o_pad_oe_n = ~drive_en;

    // Driven value from override or output latch; low when undriven
    assign o_pad_out  = drive_en & (i_value_override_en ? i_value_override_val : i_pin_output_latch);

    // Input enable: override wins, else clamp in deep sleep
    assign input_en   = i_input_en_override_en ? i_input_en_override_val : ~i_sleep_clamp;
    // Clamp to ground ahead of the synchroniser
    assign o_alt_digital_in = i_pad_in & input_en;

endmodule // ppom_pin_cell

//--- rtl/ppom_port_mux.v
// Port B pin override multiplexer with APB registers and external interrupt pin
//
// Overview of operation
// - Deep sleep modes clamp digital inputs to ground
// - Enabled external interrupt pins escape the clamp
// - Disabled change- or rise-sensed interrupt pin flags on wake
// - Pull-ups off while reset is active
// - Pull-up follows override, else direction/latch/disable 010
// - Pull-up override ignores direction, latch, disable
// - Driver enable follows override, else direction bit
// - Direction override value forces driver on/off
// - Driven value: override value or output latch
// - Toggle override inverts the output latch
// - Input enable: override, else normal/sleep state
// - Input enable override ignores sleep state
// - Timer 2 compare A pin carries PWM
// - Bit 7 is pin-change source 15
// - Bits 6..4: timer compare outputs, sources 14..12
// - Bits 3..0: SPI pins, sources 11..8
// - Direction one output; zero input, pull-up if latch one
// - Writing one to input register toggles latch
// - Global disable turns off every pull-up
// - Pin value synchronised before input register
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "ppom_consts.vh"
module ppom_port_mux #(
    parameter NPINS = 8,                         // Pins in the port
    parameter AW    = 8                          // APB address width
) (
    input  wire             i_clk,               // System I/O clock
    input  wire             i_resetn,            // Async reset, active low
    // APB slave
    input  wire             i_psel,              // Select
    input  wire             i_penable,           // Access phase
    input  wire             i_pwrite,            // Write direction
    input  wire [AW-1:0]    i_paddr,             // Byte address
    input  wire [31:0]      i_pwdata,            // Write data
    output wire             o_pready,            // Always ready
    output wire             o_pslverr,           // Unmapped address
    output wire [31:0]      o_prdata,            // Read data
    // Sleep controller
    input  wire [2:0]       i_sleep_mode,        // Current sleep mode
    // Pads of port B
    input  wire [NPINS-1:0] i_pad_in,            // Pad levels
    output wire [NPINS-1:0] o_pad_out,           // Driven levels
    output wire [NPINS-1:0] o_pad_oe_n,          // Driver enables, active low
    output wire [NPINS-1:0] o_pullup_en,         // Pull-up enables
    // External interrupt pad
    input  wire             i_extint_pad,        // Pad level
    output wire             o_extint_req,        // Interrupt request, level
    // Pin-change module
    input  wire [NPINS-1:0] i_pcint_mask,        // Per-pin pin-change enables
    input  wire             i_pcint_group_en,    // Group enable for port B
    output wire [NPINS-1:0] o_pin_change_src,    // Sources 15..8, unsynchronised
    // SPI
    input  wire             i_spi_en,            // SPI enabled
    input  wire             i_spi_master,        // SPI in master mode
    input  wire             i_spi_slave_out,     // Slave data out
    input  wire             i_spi_master_out,    // Master data out
    input  wire             i_spi_sck_out,       // Master clock out
    output wire             o_spi_master_in,     // Master data in
    output wire             o_spi_slave_in,      // Slave data in
    output wire             o_spi_sck_in,        // Slave clock in
    output wire             o_spi_ss_in,         // Slave select in
    // Timers
    input  wire             i_timer2_cmp_a_en,   // Timer 2 compare A enable
    input  wire             i_timer2_cmp_a_out,  // Timer 2 compare A / PWM
    input  wire             i_timer1_cmp_b_en,   // Timer 1 compare B enable
    input  wire             i_timer1_cmp_b_out,  // Timer 1 compare B / PWM
    input  wire             i_timer1_cmp_a_en,   // Timer 1 compare A enable
    input  wire             i_timer1_cmp_a_out,  // Timer 1 compare A / PWM
    input  wire             i_timer0_cmp_a_en,   // Timer 0 compare A enable
    input  wire             i_timer0_cmp_a_out   // Timer 0 compare A / PWM
);

    // Software state
    reg  [NPINS-1:0] pin_output_latch_ff;        // Output latches
    reg  [NPINS-1:0] nxt_pin_output_latch;
    reg  [NPINS-1:0] pin_direction_bit_ff;       // Direction bits
    reg  [NPINS-1:0] nxt_pin_direction_bit;
    reg              global_pullup_disable_ff;   // Shared disable bit
    reg              nxt_global_pullup_disable;
    reg              ext_en_ff;                  // External interrupt enable
    reg              nxt_ext_en;
    reg  [1:0]       ext_sense_ff;               // Sense selection
    reg  [1:0]       nxt_ext_sense;
    reg              ext_flag_ff;                // Sticky interrupt flag
    reg              nxt_ext_flag;
    reg              ext_prev_ff;                // Previous synced level
    reg  [31:0]      prdata_ff;                  // Read data register
    reg  [31:0]      nxt_prdata;

    // Derived signals
    wire             sleep_clamp;                // Deep sleep active
    wire             wr_en;                      // Write takes effect
    wire             addr_hit;                   // Mapped address
    wire [NPINS-1:0] pin_input_bit;              // Synchronised pin values
    wire [NPINS-1:0] alt_digital_in;             // Clamped, unsynchronised
    wire [NPINS-1:0] toggle_override_en;         // Latch toggle overrides
    wire             pcint_on;                   // Group pin-change active
    wire             spi_mst;                    // SPI enabled as master
    wire             spi_slv;                    // SPI enabled as slave
    wire [NPINS-1:0] pu_oe;                      // Pull-up override enables
    wire [NPINS-1:0] pu_ov;                      // Pull-up override values
    wire [NPINS-1:0] dd_oe;                      // Direction override enables
    wire [NPINS-1:0] dd_ov;                      // Direction override values
    wire [NPINS-1:0] pv_oe;                      // Value override enables
    wire [NPINS-1:0] pv_ov;                      // Value override values
    wire [NPINS-1:0] die_oe;                     // Input enable overrides
    wire             ext_in;                     // Clamped ext interrupt pad
    wire             ext_sync;                   // Synchronised level
    wire             ext_event;                  // Selected edge seen

    // Clamp asserted only in the three deep sleep modes
    assign sleep_clamp = (i_sleep_mode == `PPOM_SLP_POWER_DOWN) |
                         (i_sleep_mode == `PPOM_SLP_POWER_SAVE) |
                         (i_sleep_mode == `PPOM_SLP_STANDBY);

    // No module toggles port B latches
    assign toggle_override_en = `PPOM_NO_TOGGLE;

    // SPI role terms used by the four SPI pins
    assign spi_mst  = i_spi_en & i_spi_master;
    assign spi_slv  = i_spi_en & ~i_spi_master;
    assign pcint_on = i_pcint_group_en;

    // Override map of port B; bits 7..4 timers, 3..0 SPI
    // Timer pins never override direction: software must set it
    assign pu_oe = {4'h0, spi_mst, spi_slv, spi_slv, spi_slv};
    // Forced inputs keep latch-controlled pull-up unless globally disabled
    assign pu_ov = {4'h0, pin_output_latch_ff[3:0] & {4{~global_pullup_disable_ff}}};
    assign dd_oe = {4'h0, spi_mst, spi_slv, spi_slv, spi_slv};
    assign dd_ov = `PPOM_ZERO_BYTE;
    // Compare enables steer compare/PWM waveforms onto the pad
    assign pv_oe = {i_timer2_cmp_a_en, i_timer1_cmp_b_en, i_timer1_cmp_a_en, i_timer0_cmp_a_en,
                    spi_slv, spi_mst, spi_mst, 1'b0};
    assign pv_ov = {i_timer2_cmp_a_out, i_timer1_cmp_b_out, i_timer1_cmp_a_out, i_timer0_cmp_a_out,
                    i_spi_slave_out, i_spi_master_out, i_spi_sck_out, 1'b0};
    // Pin-change enabled pins keep their input alive in sleep
    assign die_oe = i_pcint_mask & {NPINS{pcint_on}};

    // One override cell per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi = gi + 1) begin : g_pin
            ppom_pin_cell u_cell (
                .i_resetn               (i_resetn),
                .i_pin_direction_bit    (pin_direction_bit_ff[gi]),
                .i_pin_output_latch     (pin_output_latch_ff[gi]),
                .i_global_pullup_disable(global_pullup_disable_ff),
                .i_sleep_clamp          (sleep_clamp),
                .i_pullup_override_en   (pu_oe[gi]),
                .i_pullup_override_val  (pu_ov[gi]),
                .i_dir_override_en      (dd_oe[gi]),
                .i_dir_override_val     (dd_ov[gi]),
                .i_value_override_en    (pv_oe[gi]),
                .i_value_override_val   (pv_ov[gi]),
                .i_input_en_override_en (die_oe[gi]),
                .i_input_en_override_val(1'b1),
                .i_pad_in               (i_pad_in[gi]),
                .o_pad_out              (o_pad_out[gi]),
                .o_pad_oe_n             (o_pad_oe_n[gi]),
                .o_pullup_en            (o_pullup_en[gi]),
                .o_alt_digital_in       (alt_digital_in[gi])
            );
        end
    endgenerate

    // Alternate inputs leave before the synchroniser; receivers sync them
    assign o_pin_change_src = alt_digital_in;
    assign o_spi_master_in  = alt_digital_in[`PPOM_PIN_MISO];
    assign o_spi_slave_in   = alt_digital_in[`PPOM_PIN_MOSI];
    assign o_spi_sck_in     = alt_digital_in[`PPOM_PIN_SCK];
    assign o_spi_ss_in      = alt_digital_in[`PPOM_PIN_SS];

    // Pin values synchronised before software sees them
    ppom_pin_sync #(
        .WIDTH (NPINS + 1)
    ) u_sync (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  ({ext_in, alt_digital_in}),
        .o_sync   ({ext_sync, pin_input_bit})
    );

    // Ext interrupt pad escapes the clamp only while enabled
    assign ext_in = i_extint_pad & (ext_en_ff | ~sleep_clamp);

    // Edge detection runs whether enabled or not, so clamp release
    // of a high pad registers as a rising edge after wake
    assign ext_event = ((ext_sense_ff == `PPOM_SENSE_CHANGE) & (ext_sync ^ ext_prev_ff)) |
                       ((ext_sense_ff == `PPOM_SENSE_FALL)   & ~ext_sync & ext_prev_ff) |
                       ((ext_sense_ff == `PPOM_SENSE_RISE)   & ext_sync & ~ext_prev_ff);
    // Low-level sense is a request by level, not a flag
    assign o_extint_req = ext_en_ff & (ext_flag_ff |
                          ((ext_sense_ff == `PPOM_SENSE_LOW) & ~ext_sync));

    // APB decode; zero wait states
    assign wr_en    = i_psel & i_penable & i_pwrite;
    assign addr_hit = (i_paddr == `PPOM_ADDR_OUT) | (i_paddr == `PPOM_ADDR_DIR) |
                      (i_paddr == `PPOM_ADDR_PIN) | (i_paddr == `PPOM_ADDR_CPU_CTRL) |
                      (i_paddr == `PPOM_ADDR_EXTINT);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_hit;
    assign o_prdata  = prdata_ff;

    // Next state of software registers
    always @* begin
        nxt_pin_output_latch      = pin_output_latch_ff;
        nxt_pin_direction_bit     = pin_direction_bit_ff;
        nxt_global_pullup_disable = global_pullup_disable_ff;
        nxt_ext_en                = ext_en_ff;
        nxt_ext_sense             = ext_sense_ff;
        nxt_ext_flag              = ext_flag_ff;
        if (wr_en) begin
            case (i_paddr)
                `PPOM_ADDR_OUT: begin
                    nxt_pin_output_latch = i_pwdata[NPINS-1:0];
                end
                `PPOM_ADDR_DIR: begin
                    nxt_pin_direction_bit = i_pwdata[NPINS-1:0];
                end
                `PPOM_ADDR_PIN: begin
                    // Ones toggle, zeros leave the latch alone
                    nxt_pin_output_latch = pin_output_latch_ff ^ i_pwdata[NPINS-1:0];
                end
                `PPOM_ADDR_CPU_CTRL: begin
                    nxt_global_pullup_disable = i_pwdata[`PPOM_CTRL_PUD_BIT];
                end
                `PPOM_ADDR_EXTINT: begin
                    nxt_ext_en    = i_pwdata[`PPOM_EXT_EN_BIT];
                    nxt_ext_sense = i_pwdata[`PPOM_EXT_SENSE_HI:`PPOM_EXT_SENSE_LO];
                    // Write one clears the flag
                    if (i_pwdata[`PPOM_EXT_FLAG_BIT]) begin
                        nxt_ext_flag = 1'b0;
                    end
                end
                default: begin
                    // Unmapped: no effect
                end
            endcase
        end
        // Toggle override acts after any software write
        nxt_pin_output_latch = nxt_pin_output_latch ^ toggle_override_en;
        // Hardware set wins over a same-cycle clear
        if (ext_event) begin
            nxt_ext_flag = 1'b1;
        end
    end

    // Read data captured in the setup phase, stable through access
    always @* begin
        nxt_prdata = prdata_ff;
        if (i_psel & ~i_penable) begin
            nxt_prdata = `PPOM_RST_WORD;
            case (i_paddr)
                `PPOM_ADDR_OUT:      nxt_prdata[NPINS-1:0] = pin_output_latch_ff;
                `PPOM_ADDR_DIR:      nxt_prdata[NPINS-1:0] = pin_direction_bit_ff;
                `PPOM_ADDR_PIN:      nxt_prdata[NPINS-1:0] = pin_input_bit;
                `PPOM_ADDR_CPU_CTRL: nxt_prdata[`PPOM_CTRL_PUD_BIT] = global_pullup_disable_ff;
                `PPOM_ADDR_EXTINT: begin
                    nxt_prdata[`PPOM_EXT_EN_BIT]    = ext_en_ff;
                    nxt_prdata[`PPOM_EXT_SENSE_HI:`PPOM_EXT_SENSE_LO] = ext_sense_ff;
                    nxt_prdata[`PPOM_EXT_FLAG_BIT]  = ext_flag_ff;
                    nxt_prdata[`PPOM_EXT_LEVEL_BIT] = ext_sync;
                end
                default:             nxt_prdata = `PPOM_RST_WORD;
            endcase
        end
    end

    // State registers; reset leaves every pin tri-stated, pull-ups off
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_output_latch_ff      <= `PPOM_RST_BYTE;
            pin_direction_bit_ff     <= `PPOM_RST_BYTE;
            global_pullup_disable_ff <= 1'b0;
            ext_en_ff                <= 1'b0;
            ext_sense_ff             <= `PPOM_RST_SENSE;
            ext_flag_ff              <= 1'b0;
            ext_prev_ff              <= 1'b0;
            prdata_ff                <= `PPOM_RST_WORD;
        end else begin
            pin_output_latch_ff      <= nxt_pin_output_latch;
            pin_direction_bit_ff     <= nxt_pin_direction_bit;
            global_pullup_disable_ff <= nxt_global_pullup_disable;
            ext_en_ff                <= nxt_ext_en;
            ext_sense_ff             <= nxt_ext_sense;
            ext_flag_ff              <= nxt_ext_flag;
            ext_prev_ff              <= ext_sync;
            prdata_ff                <= nxt_prdata;
        end
    end

endmodule // ppom_port_mux

//--- tb/ppom_port_mux_assertions.sv
// Port-level assertions for the port B pin override multiplexer
`timescale 1ns/1ns
module ppom_port_mux_assertions #(
    parameter NPINS = 8                                         // Pins in the port
) (
    input wire             i_clk, i_resetn,                     // Clock, async reset
    input wire             i_pcint_group_en, i_spi_en, i_spi_master,
    input wire             i_timer2_cmp_a_en, i_timer2_cmp_a_out,
    input wire [2:0]       i_sleep_mode,                        // Sleep controller state
    input wire [NPINS-1:0] i_pad_in, o_pad_out, o_pad_oe_n, o_pullup_en, i_pcint_mask, o_pin_change_src
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // Clamping modes; idle and noise reduction keep inputs live
    wire deep = (i_sleep_mode == 3'h3) || (i_sleep_mode == 3'h4) || (i_sleep_mode == 3'h6);
    sequence deep_no_ovr;
        deep && !i_pcint_group_en;
    endsequence
    // Reset checks run while reset is low, so they drop the default disable
    rst_pullup_a: assert property (disable iff (1'b0) !i_resetn |-> o_pullup_en == 0) else $error("pull-up in reset");
    rst_tristate_a: assert property (disable iff (1'b0) !i_resetn |-> &o_pad_oe_n) else $error("driver in reset");
    sleep_clamp_a: assert property (deep_no_ovr |-> o_pin_change_src == 0) else $error("input not clamped");
    awake_input_a: assert property (i_sleep_mode == 3'h0 |-> o_pin_change_src == i_pad_in) else $error("input lost");
    die_override_a: assert property (deep && i_pcint_group_en |-> o_pin_change_src == (i_pad_in & i_pcint_mask))
        else $error("input override ignored");
    t2_value_a: assert property (!o_pad_oe_n[7] && i_timer2_cmp_a_en |-> o_pad_out[7] == i_timer2_cmp_a_out)
        else $error("timer value not driven");
    idle_low_a: assert property ((o_pad_out & o_pad_oe_n) == 0) else $error("value while not driving");
    pullup_out_a: assert property ((o_pullup_en & ~o_pad_oe_n) == 0) else $error("pull-up on output");
    miso_in_a: assert property (i_spi_en && i_spi_master |-> o_pad_oe_n[3]) else $error("data-in pin driven");
endmodule // ppom_port_mux_assertions
bind ppom_port_mux ppom_port_mux_assertions #(.NPINS(NPINS)) ppom_port_mux_assertions_inst (.i_clk, .i_resetn,
    .i_pcint_group_en, .i_spi_en, .i_spi_master, .i_timer2_cmp_a_en, .i_timer2_cmp_a_out, .i_sleep_mode,
    .i_pad_in, .o_pad_out, .o_pad_oe_n, .o_pullup_en, .i_pcint_mask, .o_pin_change_src);

//--- tb/ppom_pad_model.sv
// Pad and board model for the eight port B lines
`timescale 1ns/1ns
module ppom_pad_model (
    input  wire  [7:0] i_ext,                                   // Weak board level
    input  wire  [7:0] i_pad_out,                               // Device drive level
    input  wire  [7:0] i_pad_oe_n,                              // Device driver, active low
    input  wire  [7:0] i_pullup_en,                             // Device pull-up
    output logic [7:0] o_pad                                    // Level seen at the trigger
);
    // Driver beats pull-up; pull-up beats the weak board level
    always_comb
        for (int n = 0; n < 8; n++)
            o_pad[n] = !i_pad_oe_n[n] ? i_pad_out[n] : (i_pullup_en[n] | i_ext[n]);
endmodule // ppom_pad_model

//--- tb/ppom_port_mux_tb.sv
// Self-checking bench for the port B pin override multiplexer
`timescale 1ns/1ns
module ppom_port_mux_tb;
    logic        i_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, sl;
    logic        i_pcint_group_en = 0, i_spi_en = 0, i_spi_master = 0, i_extint_pad = 0;
    logic        o_pready, o_pslverr, o_extint_req;            // Bus and request outputs
    logic [7:0]  i_paddr = 0, i_pcint_mask = 0, ext = 0, i_pad_in, o_pad_out, o_pad_oe_n, o_pullup_en;
    logic [7:0]  o_pin_change_src;                              // Unsynchronised sources
    logic [3:0]  ten = 0, tval = 0, si;                         // Timer enables and levels, SPI inputs
    logic [2:0]  i_sleep_mode = 0, spo = 0;                     // Sleep mode, SPI outputs
    logic [31:0] i_pwdata = 0, o_prdata, r;                     // Bus data
    integer      fail_count = 0, num_checks = 0;
    ppom_port_mux ppom_port_mux_inst (.i_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .o_pready, .o_pslverr, .o_prdata, .i_sleep_mode, .i_pad_in, .o_pad_out, .o_pad_oe_n, .o_pullup_en,
        .i_extint_pad, .o_extint_req, .i_pcint_mask, .i_pcint_group_en, .o_pin_change_src, .i_spi_en,
        .i_spi_master, .i_spi_slave_out(spo[2]), .i_spi_master_out(spo[1]), .i_spi_sck_out(spo[0]),
        .o_spi_master_in(si[3]), .o_spi_slave_in(si[2]), .o_spi_sck_in(si[1]), .o_spi_ss_in(si[0]),
        .i_timer2_cmp_a_en(ten[3]), .i_timer2_cmp_a_out(tval[3]), .i_timer1_cmp_b_en(ten[2]),
        .i_timer1_cmp_b_out(tval[2]), .i_timer1_cmp_a_en(ten[1]), .i_timer1_cmp_a_out(tval[1]),
        .i_timer0_cmp_a_en(ten[0]), .i_timer0_cmp_a_out(tval[0]));
    ppom_pad_model ppom_pad_model_inst (.i_ext(ext), .i_pad_out(o_pad_out), .i_pad_oe_n(o_pad_oe_n),
        .i_pullup_en(o_pullup_en), .o_pad(i_pad_in));
    initial forever #5 i_clk = ~i_clk;                          // 100 MHz
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        integer k;
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
        @(posedge i_clk) i_penable <= 1;
        k = 0;
        do begin @(posedge i_clk); k++; end while (o_pready !== 1'b1 && k < 20);
        r = o_prdata;
        sl = o_pslverr;
        if (k == 20) begin fail_count++; test_done; end      // Slave never answered
        {i_psel, i_penable} <= 2'b00;
        @(posedge i_clk);
    endtask
    task t_gpio;
        apb(1, 8'h04, 32'h0F); apb(1, 8'h00, 32'hC3);
        chk("pad out", 8'h03, o_pad_out); chk("driver", 8'hF0, o_pad_oe_n);
        chk("pullups", 8'hC0, o_pullup_en);
        apb(1, 8'h08, 32'h81); apb(0, 8'h00, 0); chk("toggle", 32'h42, r);
        apb(0, 8'h08, 0); chk("pins", 32'h42, r);
        apb(1, 8'h0C, 1); chk("global off", 8'h00, o_pullup_en);
        i_resetn <= 0;
        @(posedge i_clk) chk("reset pullup", 8'h00, o_pullup_en);
        i_resetn <= 1;
        @(posedge i_clk) apb(0, 8'h20, 0); chk("unmapped", 1'b1, sl);
        $display("gpio test done");
    endtask
    task t_alt;
        ten <= 4'hF; tval <= 4'hA;
        apb(1, 8'h04, 32'h70); chk("t2 undriven", 8'h20, o_pad_out);
        apb(1, 8'h04, 32'hF0); chk("timer pins", 8'hA0, o_pad_out);
        {ten, i_spi_en, i_spi_master, spo} <= 9'h01F;
        apb(1, 8'h04, 32'h0F); chk("spi dir", 8'hF8, o_pad_oe_n); chk("spi out", 8'h06, o_pad_out);
        chk("spi in", 32'h6, si);
        i_spi_en <= 0;
        apb(1, 8'h04, 32'h00); ext <= 8'hFF;
        for (int m = 0; m < 7; m++) if (m != 5) begin
            i_sleep_mode <= m[2:0];
            @(posedge i_clk) chk("clamp", (m > 2) ? 8'h00 : 8'hFF, o_pin_change_src);
        end
        {i_pcint_group_en, i_pcint_mask} <= 9'h10F;
        @(posedge i_clk) chk("input override", 8'h0F, o_pin_change_src);
        $display("alternate test done");
    endtask
    task t_ext;
        i_sleep_mode <= 3'h3; i_pcint_group_en <= 0;
        apb(1, 8'h10, 32'h06); i_extint_pad <= 1;
        apb(0, 8'h10, 0); chk("asleep", 32'h06, r);
        i_sleep_mode <= 3'h0;
        repeat (4) @(posedge i_clk);
        apb(0, 8'h10, 0); chk("wake flag", 32'h1E, r);
        apb(1, 8'h10, 32'h09); i_sleep_mode <= 3'h3;            // Enable before sleeping
        repeat (3) @(posedge i_clk) chk("no clamp", 1'b0, o_extint_req);
        i_extint_pad <= 0;
        repeat (3) @(posedge i_clk);
        chk("low level", 1'b1, o_extint_req);
        $display("external interrupt test done");
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_resetn <= 1;
        @(posedge i_clk) t_gpio;
        t_alt;
        t_ext;
        test_done;
    end
endmodule // ppom_port_mux_tb
